// [core/smbt_pkg.sv]
package smbt_pkg;

    // ------------------------------------------------------------
    // Widths and limits
    // ------------------------------------------------------------
    localparam int MOD_W = 3;
    localparam int ADDR_W = 15;
    localparam int CNT_W = 15;
    localparam int ELEM_W = 16;
    localparam int DATA_W = 16;
    localparam logic [CNT_W-1:0] CNT_MIN = 15'h0001;

    // ------------------------------------------------------------
    // Operations and errors
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_WORD_READ = 2'h0,
        OP_DWORD_READ = 2'h1,
        OP_WORD_WRITE = 2'h2,
        OP_DWORD_WRITE = 2'h3
    } smbt_op_t;

    typedef enum logic [2:0] {
        ERR_NONE = 3'h0,
        ERR_READ_TARGET_INVALID = 3'h1,
        ERR_WRITE_MODULE_ABSENT = 3'h2,
        ERR_BUFFER_RANGE = 3'h3,
        ERR_BAD_COUNT = 3'h4
    } smbt_err_t;

    // ------------------------------------------------------------
    // Request carried from the processor
    // ------------------------------------------------------------
    typedef struct packed {
        smbt_op_t op;
        logic [MOD_W-1:0] target_module_number;
        logic [ADDR_W-1:0] buffer_start_address;
        logic [ELEM_W-1:0] element_start;
        logic [CNT_W-1:0] transfer_count;
    } smbt_req_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_CHECK = 4'h2,
        ST_MOVE = 4'h4,
        ST_DONE = 4'h8
    } smbt_state_t;

endpackage

// [core/smbt_engine.sv]
`timescale 1ns/100ps

module smbt_engine #(
    parameter int MODULE_SIZE = 32768
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_B,
    // Request from processor
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire smbt_pkg::smbt_req_t REQ,
    output logic DONE,
    output smbt_pkg::smbt_err_t ERR,
    // Module presence and buffer sizes, registers per module
    input wire logic [7:0] MOD_PRESENT,
    input wire logic [8*16-1:0] MOD_BUF_SIZE,
    // Element memory port
    output logic ELEM_WE,
    output logic [smbt_pkg::ELEM_W-1:0] ELEM_ADDR,
    output logic [smbt_pkg::DATA_W-1:0] ELEM_WDATA,
    input wire logic [smbt_pkg::DATA_W-1:0] ELEM_RDATA,
    // Module buffer port
    output logic BUF_RE,
    output logic BUF_WE,
    output logic [smbt_pkg::MOD_W-1:0] BUF_MOD,
    output logic [smbt_pkg::ADDR_W-1:0] BUF_ADDR,
    output logic [smbt_pkg::DATA_W-1:0] BUF_WDATA,
    input wire logic [smbt_pkg::DATA_W-1:0] BUF_RDATA
);

    initial
    begin
        if (MODULE_SIZE < 1 || MODULE_SIZE > 32768)
            $error("MODULE_SIZE out of range");
    end

    // ------------------------------------------------------------
    // State and request capture
    // ------------------------------------------------------------
    smbt_pkg::smbt_state_t state_q;
    smbt_pkg::smbt_req_t req_q;
    logic [16:0] remain_q;
    logic [smbt_pkg::ADDR_W-1:0] baddr_q;
    logic [smbt_pkg::ELEM_W-1:0] eaddr_q;
    logic phase_q;
    logic [16:0] regs_total;
    logic [16:0] span_end;
    logic [16:0] bufsize;
    logic is_read;
    logic is_dword;
    smbt_pkg::smbt_err_t chk_err;

    assign is_read = (req_q.op == smbt_pkg::OP_WORD_READ) || (req_q.op == smbt_pkg::OP_DWORD_READ);
    assign is_dword = (req_q.op == smbt_pkg::OP_DWORD_READ) || (req_q.op == smbt_pkg::OP_DWORD_WRITE);
    assign bufsize = {1'b0, MOD_BUF_SIZE[req_q.target_module_number*16 +: 16]};
    assign regs_total = is_dword ? {1'b0, req_q.transfer_count, 1'b0} : {2'b00, req_q.transfer_count};
    assign span_end = {2'b00, req_q.buffer_start_address} + regs_total;

    always_comb
    begin
        chk_err = smbt_pkg::ERR_NONE;
        if (!MOD_PRESENT[req_q.target_module_number])
            chk_err = is_read ? smbt_pkg::ERR_READ_TARGET_INVALID : smbt_pkg::ERR_WRITE_MODULE_ABSENT;
        else if (req_q.transfer_count < smbt_pkg::CNT_MIN)
            chk_err = smbt_pkg::ERR_BAD_COUNT;
        else if ({2'b00, req_q.buffer_start_address} >= bufsize || span_end > bufsize)
            chk_err = smbt_pkg::ERR_BUFFER_RANGE;
    end

    assign REQ_READY = (state_q == smbt_pkg::ST_IDLE);

    always_ff @(posedge CORE_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            state_q <= smbt_pkg::ST_IDLE;
            req_q <= '0;
            remain_q <= 17'h0;
            baddr_q <= 15'h0;
            eaddr_q <= 16'h0;
            phase_q <= 1'b0;
            ERR <= smbt_pkg::ERR_NONE;
        end
        else
        begin
            case (state_q)
                smbt_pkg::ST_IDLE:
                begin
                    if (REQ_VALID)
                    begin
                        req_q <= REQ;
                        state_q <= smbt_pkg::ST_CHECK;
                    end
                end
                smbt_pkg::ST_CHECK:
                begin
                    ERR <= chk_err;
                    remain_q <= regs_total;
                    baddr_q <= req_q.buffer_start_address;
                    eaddr_q <= req_q.element_start;
                    phase_q <= 1'b0;
                    state_q <= (chk_err == smbt_pkg::ERR_NONE) ? smbt_pkg::ST_MOVE : smbt_pkg::ST_DONE;
                end
                smbt_pkg::ST_MOVE:
                begin
                    if (phase_q)
                    begin
                        baddr_q <= baddr_q + 15'h1;
                        eaddr_q <= eaddr_q + 16'h1;
                        remain_q <= remain_q - 17'h1;
                        if (remain_q == 17'h1)
                            state_q <= smbt_pkg::ST_DONE;
                    end
                    phase_q <= ~phase_q;
                end
                smbt_pkg::ST_DONE:
                begin
                    state_q <= smbt_pkg::ST_IDLE;
                end
                default:
                begin
                    state_q <= smbt_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Data path
    // ------------------------------------------------------------
    // Phase 0 presents the source address, phase 1 writes the sink, so both
    // memories may have a one-cycle registered read.
    assign DONE = (state_q == smbt_pkg::ST_DONE);
    assign BUF_MOD = req_q.target_module_number;
    assign BUF_ADDR = baddr_q;
    assign ELEM_ADDR = eaddr_q;
    assign BUF_RE = (state_q == smbt_pkg::ST_MOVE) && is_read && !phase_q;
    assign ELEM_WE = (state_q == smbt_pkg::ST_MOVE) && is_read && phase_q;
    assign ELEM_WDATA = BUF_RDATA;
    assign BUF_WE = (state_q == smbt_pkg::ST_MOVE) && !is_read && phase_q;
    assign BUF_WDATA = ELEM_RDATA;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_no_move_on_err;
        @(posedge CORE_CLK) disable iff (!RST_B)
        (state_q == smbt_pkg::ST_CHECK && chk_err != smbt_pkg::ERR_NONE) |=> DONE && !BUF_WE && !ELEM_WE;
    endproperty
    a_no_move_on_err: assert property (p_no_move_on_err) else $error("transfer not abandoned");

    property p_read_absent;
        @(posedge CORE_CLK) disable iff (!RST_B)
        (state_q == smbt_pkg::ST_CHECK && is_read && !MOD_PRESENT[req_q.target_module_number])
        |=> ERR == smbt_pkg::ERR_READ_TARGET_INVALID;
    endproperty
    a_read_absent: assert property (p_read_absent) else $error("read absent module error wrong");

    property p_write_absent;
        @(posedge CORE_CLK) disable iff (!RST_B)
        (state_q == smbt_pkg::ST_CHECK && !is_read && !MOD_PRESENT[req_q.target_module_number])
        |=> ERR == smbt_pkg::ERR_WRITE_MODULE_ABSENT;
    endproperty
    a_write_absent: assert property (p_write_absent) else $error("write absent module error wrong");

    property p_range;
        @(posedge CORE_CLK) disable iff (!RST_B)
        (state_q == smbt_pkg::ST_CHECK && MOD_PRESENT[req_q.target_module_number]
         && req_q.transfer_count != 15'h0 && span_end > bufsize)
        |=> ERR == smbt_pkg::ERR_BUFFER_RANGE;
    endproperty
    a_range: assert property (p_range) else $error("range error missed");

    property p_no_buf_write_on_read;
        @(posedge CORE_CLK) disable iff (!RST_B)
        is_read |-> !BUF_WE;
    endproperty
    a_no_buf_write_on_read: assert property (p_no_buf_write_on_read) else $error("buffer written on read");

    sequence s_step;
        BUF_RE ##1 ELEM_WE;
    endsequence
    property p_read_step;
        @(posedge CORE_CLK) disable iff (!RST_B)
        BUF_RE |-> s_step;
    endproperty
    a_read_step: assert property (p_read_step) else $error("read step incomplete");

    property p_ascending;
        @(posedge CORE_CLK) disable iff (!RST_B)
        (BUF_WE && state_q == smbt_pkg::ST_MOVE && remain_q > 17'h1) |=> ##1 BUF_ADDR == $past(BUF_ADDR, 2) + 15'h1;
    endproperty
    a_ascending: assert property (p_ascending) else $error("buffer address not ascending");

    property p_dword_len;
        @(posedge CORE_CLK) disable iff (!RST_B)
        (state_q == smbt_pkg::ST_CHECK && is_dword && chk_err == smbt_pkg::ERR_NONE)
        |=> remain_q == {1'b0, $past(req_q.transfer_count), 1'b0};
    endproperty
    a_dword_len: assert property (p_dword_len) else $error("double length wrong");

endmodule // smbt_engine

// [testbench/smbt_module_model.sv]
`timescale 1ns/100ps

// ------------------------------------------------------------
// Eight special modules behind one buffer port
// ------------------------------------------------------------
module smbt_module_model (
    // Clock
    input wire logic clk,
    // Buffer port
    input wire logic re,
    input wire logic we,
    input wire logic [2:0] mod_sel,
    input wire logic [14:0] addr,
    input wire logic [15:0] wdata,
    output logic [15:0] rdata
);
    logic [15:0] mem [0:7][0:63];

    always @(posedge clk)
    begin
        if (we)
            mem[mod_sel][addr[5:0]] <= wdata;
        // An idle port flips its data each cycle, so a stale word looks valid again on every second idle cycle.
        rdata <= re ? mem[mod_sel][addr[5:0]] : ~rdata;
    end
endmodule // smbt_module_model

// [testbench/special_module_buffer_transfer_bench.sv]
`timescale 1ns/100ps

module special_module_buffer_transfer_bench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic req_valid = 1'b0;
    logic req_ready, done, elem_we, buf_re, buf_we;
    smbt_pkg::smbt_req_t req = '0;
    smbt_pkg::smbt_err_t err;
    logic [7:0] present = 8'hfe;
    logic [127:0] sizes = '0;
    logic [15:0] elem_addr, elem_wdata, elem_rdata, buf_wdata, buf_rdata;
    logic [2:0] buf_mod;
    logic [14:0] buf_addr;
    logic [15:0] elem [0:255];
    logic [15:0] x_elem [0:255];
    logic [15:0] x_buf [0:7][0:63];
    int num_errors = 0;
    int checks_done = 0;
    int m, s;

    always #2.5 clk = ~clk;

    // Element memory, read data one cycle after the address.
    always @(posedge clk)
    begin
        if (elem_we)
            elem[elem_addr[7:0]] <= elem_wdata;
        elem_rdata <= elem[elem_addr[7:0]];
    end

    smbt_engine DUT (.CORE_CLK(clk), .RST_B(rst_b), .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ(req),
        .DONE(done), .ERR(err), .MOD_PRESENT(present), .MOD_BUF_SIZE(sizes), .ELEM_WE(elem_we),
        .ELEM_ADDR(elem_addr), .ELEM_WDATA(elem_wdata), .ELEM_RDATA(elem_rdata), .BUF_RE(buf_re),
        .BUF_WE(buf_we), .BUF_MOD(buf_mod), .BUF_ADDR(buf_addr), .BUF_WDATA(buf_wdata), .BUF_RDATA(buf_rdata));

    smbt_module_model u_mod (.clk(clk), .re(buf_re), .we(buf_we), .mod_sel(buf_mod), .addr(buf_addr),
        .wdata(buf_wdata), .rdata(buf_rdata));

    task summarize();
        $display("Checks %0d, errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Op bit 0 marks a double transfer, bit 1 a write.
    function smbt_pkg::smbt_req_t mk(input int op, input int md, input int a, input int e, input int c);
        mk = {2'(op), 3'(md), 15'(a), 16'(e), 15'(c)};
    endfunction

    function smbt_pkg::smbt_err_t exp_err(input smbt_pkg::smbt_req_t r, input int regs);
        int sz;
        sz = sizes[16*r.target_module_number +: 16];
        if (!present[r.target_module_number])
            return r.op[1] ? smbt_pkg::ERR_WRITE_MODULE_ABSENT : smbt_pkg::ERR_READ_TARGET_INVALID;
        if (r.transfer_count == 0)
            return smbt_pkg::ERR_BAD_COUNT;
        if (r.buffer_start_address >= sz || r.buffer_start_address + regs > sz)
            return smbt_pkg::ERR_BUFFER_RANGE;
        return smbt_pkg::ERR_NONE;
    endfunction

    task xfer(input smbt_pkg::smbt_req_t r);
        int n, regs, md, a, e;
        smbt_pkg::smbt_err_t x;
        regs = (r.op[0] ? 2 : 1) * r.transfer_count;
        x = exp_err(r, regs);
        md = r.target_module_number;
        a = r.buffer_start_address;
        e = r.element_start;
        check(16'(req_ready), 16'h1);
        for (int i = 0; i < regs && x == smbt_pkg::ERR_NONE; i++)
            if (r.op[1])
                x_buf[md][a+i] = x_elem[(e+i)%256];
            else
                x_elem[(e+i)%256] = x_buf[md][a+i];
        req <= r;
        req_valid <= 1'b1;
        @(posedge clk);
        #1 req_valid = 1'b0;
        check(16'(req_ready), 16'h0);
        n = 0;
        while (done !== 1'b1 && n < 300)
        begin
            @(posedge clk);
            #1 n++;
        end
        if (n == 300)
        begin
            num_errors++;
            $display("Error at %0t: no completion", $time);
            summarize();
        end
        check(16'(n), 16'(x == smbt_pkg::ERR_NONE ? 1 + 2*regs : 1));
        check(16'(err), 16'(x));
        @(posedge clk);
        #1;
        check(16'(done), 16'h0);
        for (int i = 0; i < 256; i++)
            check(elem[i], x_elem[i]);
        for (int i = 0; i < 64; i++)
            check(u_mod.mem[md][i], x_buf[md][i]);
    endtask

    initial
    begin
        void'($urandom(32'hed5c3ac0));
        for (int k = 0; k < 8; k++)
            sizes[16*k +: 16] = 16'(16 + 4*k);
        for (int i = 0; i < 512; i++)
        begin
            x_buf[i/64][i%64] = 16'($urandom);
            u_mod.mem[i/64][i%64] = x_buf[i/64][i%64];
            x_elem[i%256] = 16'($urandom);
            elem[i%256] = x_elem[i%256];
        end
        repeat (20) @(posedge clk);
        #1 rst_b = 1'b1;
        // Absent module on both sides, zero count, then range edges.
        xfer(mk(0, 0, 0, 0, 1));
        xfer(mk(2, 0, 0, 0, 1));
        xfer(mk(1, 1, 0, 0, 0));
        xfer(mk(0, 1, 19, 10, 1));
        xfer(mk(3, 2, 22, 40, 1));
        xfer(mk(1, 2, 23, 40, 1));
        xfer(mk(2, 3, 28, 0, 1));
        xfer(mk(3, 7, 14, 60, 15));
        // Reset in the middle of a read; the element memory keeps whatever landed.
        req <= mk(0, 7, 0, 0, 10);
        req_valid <= 1'b1;
        @(posedge clk);
        #1 req_valid = 1'b0;
        repeat (5) @(posedge clk);
        #1 rst_b = 1'b0;
        #1;
        check(16'(req_ready), 16'h1);
        check(16'(done), 16'h0);
        check(16'(buf_re), 16'h0);
        check(16'(elem_we), 16'h0);
        check(16'(buf_we), 16'h0);
        check(16'(err), 16'(smbt_pkg::ERR_NONE));
        @(posedge clk);
        #1 rst_b = 1'b1;
        for (int i = 0; i < 256; i++)
            x_elem[i] = elem[i];
        xfer(mk(0, 7, 4, 100, 6));
        repeat (60)
        begin
            present = 8'($urandom | $urandom);
            m = $urandom % 8;
            sizes[16*m +: 16] = 16'(8 + $urandom % 40);
            s = sizes[16*m +: 16];
            xfer(mk($urandom % 4, m, $urandom % (s + 2), $urandom % 128, $urandom % 13));
        end
        summarize();
    end
endmodule // special_module_buffer_transfer_bench
